/* File: verilog/iecb_pkg.sv */
// package: register map, field layout and carrier types of the interrupt enable bank
package iecb_pkg;
    localparam int unsigned APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_EN_CORE = 8'h04;
    localparam logic [APB_AW-1:0] OFS_EN_CLKADC = 8'h08;
    localparam logic [APB_AW-1:0] OFS_EN_ANALOG = 8'h0c;
    localparam logic [APB_AW-1:0] OFS_EN_SERIAL = 8'h10;
    localparam logic [APB_AW-1:0] OFS_EN_TIMERS = 8'h14;
    localparam logic [APB_AW-1:0] OFS_EVT_STATUS = 8'h18;
    localparam logic [APB_AW-1:0] OFS_EVT_MASK = 8'h1c;

    // control register fields
    localparam int unsigned CTRL_GIE_BIT = 7;
    localparam int unsigned CTRL_PERIPH_GROUP_ENABLE_BIT = 6;
    localparam int unsigned CTRL_EDGE_BIT = 0;
    localparam logic [7:0] CTRL_MASK = 8'hc1;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    // implemented bits of each enable register
    localparam logic [7:0] EN_CORE_MASK = 8'h31;
    localparam logic [7:0] EN_CLKADC_MASK = 8'hc1;
    localparam logic [7:0] EN_ANALOG_MASK = 8'h43;
    localparam logic [7:0] EN_ANALOG_SMALL_MASK = 8'h41;
    localparam logic [7:0] EN_SERIAL_MASK = 8'h33;
    localparam logic [7:0] EN_TIMERS_MASK = 8'h03;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam int unsigned EXT_PIN_EN_BIT = 0;

    // event status / mask layout
    localparam int unsigned EVT_EXT_PIN = 0;
    localparam int unsigned EVT_VECTOR = 1;
    localparam int unsigned EVT_RETURN = 2;
    localparam logic [7:0] EVT_MASK = 8'h07;
    localparam logic [7:0] EVT_RESET = 8'h00;

    localparam logic [15:0] VECTOR_ADDR = 16'h0004;

    // source flags, one byte per enable register, same bit layout
    typedef struct packed {
        logic [7:0] timers;
        logic [7:0] serial;
        logic [7:0] analog;
        logic [7:0] clkAdc;
        logic [7:0] core;
    } iecb_flags_s;

    // vectoring request towards the core sequencer
    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } iecb_vector_s;
endpackage

/* File: verilog/iecb_irq_enable_bank.sv */
// interrupt control and enable register bank with apb slave and vectoring request
// Function
// - global enable bit 7 of control blocks all vectoring when zero
// - peripheral enable bit 6 gates all peripheral-group sources
// - edge select bit 0: one rising, zero falling; resets to one
// - sources in enable registers 1..4 also need the peripheral enable
// - enable register 0 sources need only the global enable
// - enable register 0: timer0 bit 5, pin change bit 4, external pin bit 0
// - enable register 1: oscillator fail bit 7, clock switch bit 6, adc bit 0
// - enable register 2: zero cross bit 6, comparator 2 bit 1, comparator 1 bit 0
// - enable register 3: usart rx 5, tx 4, collision 1, serial event 0
// - enable register 4: timer2 match bit 1, timer1 overflow bit 0
// - unimplemented bits ignore writes and read as zero
// - all enable bits including global and peripheral clear on reset
// - flags set by events regardless of any enable bit
// - vectoring clears global enable to 0004h; return sets it again
// - external pin flag set on an edge of the selected polarity
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module iecb_irq_enable_bank
    import iecb_pkg::*;
#(
    parameter bit HAS_COMP2 = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire iecb_flags_s srcFlags,
    input wire logic extPin,
    input wire logic vectorAck,
    input wire logic returnFromHandler,
    output iecb_vector_s vectorOut,
    output logic extPinFlag,
    output logic irqOut
);
    localparam logic [7:0] EN_ANALOG_IMPL = HAS_COMP2 ? EN_ANALOG_MASK : EN_ANALOG_SMALL_MASK;

    logic [7:0] ctrlQ;
    logic [7:0] enCoreQ;
    logic [7:0] enClkAdcQ;
    logic [7:0] enAnalogQ;
    logic [7:0] enSerialQ;
    logic [7:0] enTimersQ;
    logic [7:0] evtStatusQ;
    logic [7:0] evtMaskQ;
    logic extPinPrevQ;
    logic readyQ;
    logic errQ;
    logic [31:0] rdataQ;
    logic vecReqQ;
    logic irqQ;

    // decode of the map, used by the error answer only; the read mux decodes on its own
    function automatic logic addrMapped(input logic [APB_AW-1:0] a);
        case (a)
            OFS_CTRL, OFS_EN_CORE, OFS_EN_CLKADC, OFS_EN_ANALOG,
            OFS_EN_SERIAL, OFS_EN_TIMERS, OFS_EVT_STATUS, OFS_EVT_MASK: addrMapped = 1'b1;
            default: addrMapped = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] readByte(input logic [APB_AW-1:0] a, input logic [7:0] ctl,
        input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3,
        input logic [7:0] e4, input logic [7:0] st, input logic [7:0] mk);
        case (a)
            OFS_CTRL: readByte = ctl;
            OFS_EN_CORE: readByte = e0;
            OFS_EN_CLKADC: readByte = e1;
            OFS_EN_ANALOG: readByte = e2;
            OFS_EN_SERIAL: readByte = e3;
            OFS_EN_TIMERS: readByte = e4;
            OFS_EVT_STATUS: readByte = st;
            OFS_EVT_MASK: readByte = mk;
            default: readByte = 8'h00;
        endcase
    endfunction

    logic setupPhase;
    logic wrAccess;
    logic gieQ;
    logic peieQ;
    logic edgeSelQ;
    logic rawEdge;
    logic [7:0] coreFlags;
    logic coreHit;
    logic periphHit;
    logic [7:0] evtSet;

    assign setupPhase = psel && !penable;
    // a write takes effect only at the edge where the access completes
    assign wrAccess = psel && penable && readyQ && pwrite && !errQ;
    assign gieQ = ctrlQ[CTRL_GIE_BIT];
    assign peieQ = ctrlQ[CTRL_PERIPH_GROUP_ENABLE_BIT];
    assign edgeSelQ = ctrlQ[CTRL_EDGE_BIT];

    // pin is taken as synchronous; edge qualified by the selected polarity
    assign rawEdge = edgeSelQ ? (extPin && !extPinPrevQ) : (!extPin && extPinPrevQ);

    // the pin flag replaces whatever the source bus carries in bit 0
    assign coreFlags = {srcFlags.core[7:1], evtStatusQ[EVT_EXT_PIN]};
    assign coreHit = |(coreFlags & enCoreQ);
    assign periphHit = peieQ && |({srcFlags.clkAdc & enClkAdcQ, srcFlags.analog & enAnalogQ,
        srcFlags.serial & enSerialQ, srcFlags.timers & enTimersQ});

    always_comb begin
        evtSet = 8'h00;
        evtSet[EVT_EXT_PIN] = rawEdge;
        evtSet[EVT_VECTOR] = vectorAck && vecReqQ;
        evtSet[EVT_RETURN] = returnFromHandler;
    end

    // apb answer: one wait-free access phase, registered pready
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            readyQ <= 1'b0;
            errQ <= 1'b0;
            rdataQ <= 32'h0000_0000;
        end else begin
            readyQ <= setupPhase;
            errQ <= setupPhase && !addrMapped(paddr);
            if (setupPhase && !pwrite) begin
                rdataQ <= {24'h00_0000, readByte(paddr, ctrlQ, enCoreQ, enClkAdcQ, enAnalogQ,
                    enSerialQ, enTimersQ, evtStatusQ, evtMaskQ)};
            end else if (setupPhase) begin
                rdataQ <= 32'h0000_0000;
            end
        end
    end

    // control register; hardware vectoring and return override a software write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrlQ <= CTRL_RESET;
        end else begin
            if (wrAccess && paddr == OFS_CTRL) begin
                ctrlQ <= pwdata[7:0] & CTRL_MASK;
            end
            if (vectorAck && vecReqQ) begin
                ctrlQ[CTRL_GIE_BIT] <= 1'b0;
            end
            if (returnFromHandler) begin
                ctrlQ[CTRL_GIE_BIT] <= 1'b1;
            end
        end
    end

    // enable registers; reserved positions are masked off at write time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enCoreQ <= EN_RESET;
            enClkAdcQ <= EN_RESET;
            enAnalogQ <= EN_RESET;
            enSerialQ <= EN_RESET;
            enTimersQ <= EN_RESET;
        end else if (wrAccess) begin
            case (paddr)
                OFS_EN_CORE: enCoreQ <= pwdata[7:0] & EN_CORE_MASK;
                OFS_EN_CLKADC: enClkAdcQ <= pwdata[7:0] & EN_CLKADC_MASK;
                OFS_EN_ANALOG: enAnalogQ <= pwdata[7:0] & EN_ANALOG_IMPL;
                OFS_EN_SERIAL: enSerialQ <= pwdata[7:0] & EN_SERIAL_MASK;
                OFS_EN_TIMERS: enTimersQ <= pwdata[7:0] & EN_TIMERS_MASK;
                default: ;
            endcase
        end
    end

    // sticky events, write one to clear; a new event in the clear cycle wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            evtStatusQ <= EVT_RESET;
            evtMaskQ <= EVT_RESET;
        end else begin
            if (wrAccess && paddr == OFS_EVT_STATUS) begin
                evtStatusQ <= ((evtStatusQ & ~pwdata[7:0]) | evtSet) & EVT_MASK;
            end else begin
                evtStatusQ <= (evtStatusQ | evtSet) & EVT_MASK;
            end
            if (wrAccess && paddr == OFS_EVT_MASK) begin
                evtMaskQ <= pwdata[7:0] & EVT_MASK;
            end
        end
    end

    // edge detector history; reset low so a high pin at release looks like a rise
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            extPinPrevQ <= 1'b0;
        end else begin
            extPinPrevQ <= extPin;
        end
    end

    // request to the sequencer, one cycle behind the enables it depends on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vecReqQ <= 1'b0;
        end else begin
            vecReqQ <= gieQ && (coreHit || periphHit) && !(vectorAck && vecReqQ);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqQ <= 1'b0;
        end else begin
            irqQ <= |(((evtStatusQ | evtSet) & EVT_MASK) & evtMaskQ);
        end
    end

    assign prdata = rdataQ;
    assign pready = readyQ;
    assign pslverr = errQ;
    assign vectorOut.req = vecReqQ;
    assign vectorOut.addr = VECTOR_ADDR;
    assign extPinFlag = evtStatusQ[EVT_EXT_PIN];
    assign irqOut = irqQ;

    // ---------------- assertions ----------------
    property p_global_gate;
        @(posedge mclk) disable iff (rst) !gieQ |=> !vecReqQ;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("request while global enable off");

    property p_periph_gate;
        @(posedge mclk) disable iff (rst)
            (gieQ && !peieQ && !coreHit && !(vectorAck && vecReqQ)) |=> !vecReqQ;
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral source passed periph_group_enable");

    property p_periph_pass;
        @(posedge mclk) disable iff (rst)
            (gieQ && peieQ && (srcFlags.timers & enTimersQ) != 8'h00 && !vectorAck)
            |=> vecReqQ;
    endproperty
    a_periph_pass: assert property (p_periph_pass) else $error("enabled peripheral source lost");

    property p_core_group;
        @(posedge mclk) disable iff (rst) (gieQ && !peieQ && coreHit && !vectorAck) |=> vecReqQ;
    endproperty
    a_core_group: assert property (p_core_group) else $error("core group source blocked");

    property p_ext_edge;
        @(posedge mclk) disable iff (rst)
            (edgeSelQ && extPin && !extPinPrevQ) |=> extPinFlag;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("rising edge not flagged");

    property p_ext_fall;
        @(posedge mclk) disable iff (rst)
            (!edgeSelQ && !extPin && extPinPrevQ) |=> ##1 irqOut || !evtMaskQ[EVT_EXT_PIN];
    endproperty
    a_ext_fall: assert property (p_ext_fall) else $error("falling edge not seen");

    property p_unimpl_zero;
        @(posedge mclk) disable iff (rst)
            (ctrlQ & ~CTRL_MASK) == 8'h00 && (enCoreQ & ~EN_CORE_MASK) == 8'h00
            && (enClkAdcQ & ~EN_CLKADC_MASK) == 8'h00 && (enAnalogQ & ~EN_ANALOG_IMPL) == 8'h00
            && (enSerialQ & ~EN_SERIAL_MASK) == 8'h00 && (enTimersQ & ~EN_TIMERS_MASK) == 8'h00
            && prdata[31:8] == 24'h00_0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("reserved bit set");

    property p_vector_clears;
        @(posedge mclk) disable iff (rst)
            (vectorAck && vecReqQ && !returnFromHandler) |=> !gieQ ##1 !vecReqQ;
    endproperty
    a_vector_clears: assert property (p_vector_clears) else $error("global enable kept on vector");

    property p_return_sets;
        @(posedge mclk) disable iff (rst) returnFromHandler |=> gieQ;
    endproperty
    a_return_sets: assert property (p_return_sets) else $error("return did not set enable");

    property p_reset_state;
        @(posedge mclk) $fell(rst) |-> ctrlQ == CTRL_RESET && enCoreQ == EN_RESET
            && enTimersQ == EN_RESET && !vecReqQ;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

    property p_apb_answer;
        @(posedge mclk) disable iff (rst) (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");

    c_vector: cover property (@(posedge mclk) disable iff (rst) vecReqQ ##1 vectorAck);
    c_ext_irq: cover property (@(posedge mclk) disable iff (rst) $rose(extPinFlag) ##1 irqOut);
    c_return: cover property (@(posedge mclk) disable iff (rst) !gieQ ##1 returnFromHandler);
    c_err: cover property (@(posedge mclk) disable iff (rst) pready && pslverr);
endmodule
`default_nettype wire

/* File: test/iecb_core_model.sv */
// core sequencer model: takes vectoring requests and issues handler returns
`timescale 1ns/1ps
`default_nettype none
module iecb_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req,
    input wire logic ackEn,
    input wire logic [3:0] ackDelay,
    input wire logic retReq,
    output logic vectorAck,
    output logic returnFromHandler
);
    logic [3:0] waitCnt_q;
    // ack is a one-cycle pulse, never repeated while the request drops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            waitCnt_q <= 4'h0;
            vectorAck <= 1'b0;
        end else begin
            vectorAck <= 1'b0;
            if (!req || vectorAck || !ackEn) begin
                waitCnt_q <= 4'h0;
            end else if (waitCnt_q == ackDelay) begin
                vectorAck <= 1'b1;
                waitCnt_q <= 4'h0;
            end else begin
                waitCnt_q <= waitCnt_q + 4'h1;
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            returnFromHandler <= 1'b0;
        end else begin
            returnFromHandler <= retReq;
        end
    end
endmodule
`default_nettype wire

/* File: test/irq_enable_control_bank_tb.sv */
// testbench: apb register checks, vectoring gates and external pin events
`timescale 1ns/1ps
`default_nettype none
module irq_enable_control_bank_tb;
    import iecb_pkg::*;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, extPin, extPinFlag, irqOut;
    logic vectorAck, returnFromHandler, ackEn, retReq;
    logic [3:0] ackDelay;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic rdErr;
    iecb_flags_s flags;
    iecb_vector_s vecOut;
    int n_fail, num_checks, i;
    logic [7:0] implMask [6] = '{8'hc1, 8'h31, 8'hc1, 8'h43, 8'h33, 8'h03};

    iecb_irq_enable_bank i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcFlags(flags), .extPin(extPin), .vectorAck(vectorAck),
        .returnFromHandler(returnFromHandler), .vectorOut(vecOut), .extPinFlag(extPinFlag),
        .irqOut(irqOut));
    iecb_core_model i_core (.mclk(mclk), .rst(rst), .req(vecOut.req), .ackEn(ackEn),
        .ackDelay(ackDelay), .retReq(retReq), .vectorAck(vectorAck),
        .returnFromHandler(returnFromHandler));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask

    // request held from setup until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            complete_run();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask

    task automatic waitReq(input logic v);
        int k;
        for (k = 0; k < 20 && vecOut.req !== v; k++) begin
            @(posedge mclk);
        end
        if (vecOut.req !== v) begin
            n_fail++;
            complete_run();
        end
    endtask

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, extPin, ackEn, retReq} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        ackDelay = 4'h0;
        flags = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rdData, (i == 0) ? 32'h1 : 32'h0);
        end
        for (i = 0; i < 6; i++) begin
            apb(1'b1, 8'(i * 4), 32'hffffffff);
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("implemented bits", rdData, {24'h0, implMask[i]});
            apb(1'b1, 8'(i * 4), 32'h0);
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("cleared bits", rdData, 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", {31'h0, rdErr}, 32'h1);
        chk("unmapped data", rdData, 32'h0);
        $display("test registers done");
        apb(1'b1, OFS_EN_CORE, 32'h20);
        flags.core[5] <= 1'b1;
        settle();
        chk("req global off", {31'h0, vecOut.req}, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h81);
        settle();
        chk("req core group", {31'h0, vecOut.req}, 32'h1);
        chk("vector addr", {16'h0, vecOut.addr}, 32'h4);
        ackEn <= 1'b1;
        waitReq(1'b0);
        ackEn <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("global cleared", rdData, 32'h1);
        apb(1'b0, OFS_EVT_STATUS, 32'h0);
        chk("vector event", rdData, 32'h2);
        apb(1'b1, OFS_EVT_STATUS, 32'h2);
        apb(1'b1, OFS_EN_CORE, 32'h0);
        flags.core[5] <= 1'b0;
        $display("test core group done");
        flags.clkAdc[0] <= 1'b1;
        apb(1'b1, OFS_EN_CLKADC, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h81);
        settle();
        chk("req periph off", {31'h0, vecOut.req}, 32'h0);
        apb(1'b1, OFS_CTRL, 32'hc1);
        settle();
        chk("req periph on", {31'h0, vecOut.req}, 32'h1);
        ackDelay <= 4'h3;
        ackEn <= 1'b1;
        waitReq(1'b0);
        ackEn <= 1'b0;
        @(posedge mclk);
        retReq <= 1'b1;
        @(posedge mclk);
        retReq <= 1'b0;
        settle();
        chk("req after return", {31'h0, vecOut.req}, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("global restored", rdData, 32'hc1);
        apb(1'b1, OFS_CTRL, 32'h0);
        flags.clkAdc[0] <= 1'b0;
        $display("test peripheral group done");
        apb(1'b1, OFS_EVT_MASK, 32'h1);
        extPin <= 1'b1;
        settle();
        chk("rising ignored", {31'h0, extPinFlag}, 32'h0);
        extPin <= 1'b0;
        settle();
        chk("falling flag", {31'h0, extPinFlag}, 32'h1);
        chk("irq raised", {31'h0, irqOut}, 32'h1);
        apb(1'b1, OFS_EVT_MASK, 32'h0);
        settle();
        chk("irq masked", {31'h0, irqOut}, 32'h0);
        apb(1'b1, OFS_EVT_MASK, 32'h1);
        apb(1'b1, OFS_EVT_STATUS, 32'h1);
        settle();
        chk("flag cleared", {30'h0, extPinFlag, irqOut}, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        extPin <= 1'b1;
        settle();
        chk("rising flag", {31'h0, extPinFlag}, 32'h1);
        $display("test external pin done");
        complete_run();
    end
endmodule
`default_nettype wire
